// File: src/ash_dev_port.sv
// converter end of the serial port: clocking, shift engine and register file
`timescale 1ns/1ns
module ash_dev_port (
   // clock (master_oscillator) and reset
   input wire logic pclk,
   input wire logic presetn,
   // serial link
   ash_link_if.dev link,
   // converter core
   input wire logic conv_load,
   input wire logic [23:0] conv_result,
   output logic [23:0] setup_control,
   output logic [23:0] zero_point_cal,
   output logic [23:0] positive_span_cal,
   output logic [23:0] negative_span_cal
);
   // =====================================================================
   // self-clock generator
   ash_pkg::ash_sc_t sc_r, sc_nxt;
   logic [5:0] cnt_r, cnt_nxt;
   logic sclk_r, sclk_nxt;
   logic sclk_oe_r, sclk_oe_nxt;
   logic sc_fall, sc_rise;
   logic self_mode;

   assign self_mode = link.clock_mode;

   always_comb begin
      sc_nxt = sc_r;
      cnt_nxt = cnt_r + 6'h01;
      sclk_nxt = sclk_r;
      sc_fall = 1'b0;
      sc_rise = 1'b0;
      sclk_oe_nxt = self_mode;
      unique case (sc_r)
         ash_pkg::SC_IDLE: begin
            cnt_nxt = 6'h00;
            sclk_nxt = 1'b1;
            if (self_mode && !link.cs_n) begin
               sc_nxt = ash_pkg::SC_LEAD;
            end
         end
         ash_pkg::SC_LEAD: begin
            // the sampling edge itself counts as one of the lead cycles
            if (cnt_r == 6'(ash_pkg::LEAD_CYC - 2)) begin
               cnt_nxt = 6'h00;
               sc_nxt = ash_pkg::SC_SHIFT;
            end
         end
         ash_pkg::SC_SHIFT: begin
            // chip select is not looked at here, so a started byte always ends
            if (cnt_r[1:0] == 2'h0) begin
               sclk_nxt = cnt_r[2];
               sc_fall = !cnt_r[2];
               sc_rise = cnt_r[2];
            end
            if (cnt_r == 6'(ash_pkg::BYTE_TICKS - 1)) begin
               cnt_nxt = 6'h00;
               sc_nxt = ash_pkg::SC_STALL;
            end
         end
         ash_pkg::SC_STALL: begin
            if (cnt_r == 6'(ash_pkg::STALL_CYC - 1)) begin
               cnt_nxt = 6'h00;
               sc_nxt = link.cs_n ? ash_pkg::SC_IDLE : ash_pkg::SC_SHIFT;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sc_r <= ash_pkg::SC_IDLE;
         cnt_r <= 6'h00;
         sclk_r <= 1'b1;
         sclk_oe_r <= 1'b0;
      end else begin
         sc_r <= sc_nxt;
         cnt_r <= cnt_nxt;
         sclk_r <= sclk_nxt;
         sclk_oe_r <= sclk_oe_nxt;
      end
   end

   // =====================================================================
   // shift engine and registers
   ash_pkg::ash_phase_t phase_r, phase_nxt;
   logic [23:0] regs_r [ash_pkg::NUM_REGS];
   logic [23:0] regs_nxt [ash_pkg::NUM_REGS];
   logic rw_r, rw_nxt;
   logic [1:0] left_r, left_nxt;
   logic [2:0] sel_r, sel_nxt;
   logic [1:0] ptr_r, ptr_nxt;
   logic [2:0] bit_r, bit_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic [2:0] rmask_r, rmask_nxt;
   logic pend_n_r, pend_n_nxt;
   logic dout_r, dout_nxt;
   logic sdio_oe_r, sdio_oe_nxt;
   logic sol_oe_r, sol_oe_nxt;
   logic sclk_prev_r;
   logic ev_fall, ev_rise;
   logic [2:0] pos;
   logic [7:0] cur_byte;
   logic [7:0] done_byte;
   logic reading, drive_en, bidir;

   // external clock edges only count while selected, which freezes the cycle
   assign ev_fall = self_mode ? sc_fall : (!link.cs_n && sclk_prev_r && !link.sclk);
   assign ev_rise = self_mode ? sc_rise : (!link.cs_n && !sclk_prev_r && link.sclk);
   assign bidir = regs_r[ash_pkg::RI_CTRL][ash_pkg::CTRL_BIDIR_BIT];
   assign reading = (phase_r == ash_pkg::PH_DATA) && !rw_r;
   // self clock keeps driving through a byte even when deselected
   assign drive_en = self_mode ? (sc_r == ash_pkg::SC_SHIFT || !link.cs_n) : !link.cs_n;

   always_comb begin
      phase_nxt = phase_r;
      regs_nxt = regs_r;
      rw_nxt = rw_r;
      left_nxt = left_r;
      sel_nxt = sel_r;
      ptr_nxt = ptr_r;
      bit_nxt = bit_r;
      sh_nxt = sh_r;
      rmask_nxt = rmask_r;
      pend_n_nxt = pend_n_r;
      dout_nxt = dout_r;
      // instruction bytes are always msb first
      if (phase_r == ash_pkg::PH_DATA && regs_r[ash_pkg::RI_CTRL][ash_pkg::CTRL_LSBF_BIT]) begin
         pos = bit_r;
      end else begin
         pos = 3'h7 - bit_r;
      end
      cur_byte = (ptr_r == 2'h3) ? 8'h00 : regs_r[sel_r][{ptr_r, 3'h0} +: 8];
      done_byte = sh_r;
      done_byte[pos] = link.sdio;
      if (ev_fall && reading) begin
         dout_nxt = cur_byte[pos];
      end
      if (ev_rise) begin
         sh_nxt = done_byte;
         bit_nxt = bit_r + 3'h1;
         if (bit_r == 3'h7) begin
            if (phase_r == ash_pkg::PH_INSTR) begin
               rw_nxt = done_byte[ash_pkg::INS_RW_BIT];
               left_nxt = done_byte[ash_pkg::INS_MB_LSB +: 2];
               ptr_nxt = done_byte[ash_pkg::INS_BYTE_LSB +: 2];
               if (done_byte[ash_pkg::INS_REG_LSB +: 2] == 2'h3) begin
                  sel_nxt = done_byte[ash_pkg::INS_FSC_BIT] ? ash_pkg::RI_NSPAN
                                                           : ash_pkg::RI_PSPAN;
               end else begin
                  sel_nxt = {1'b0, done_byte[ash_pkg::INS_REG_LSB +: 2]};
               end
               phase_nxt = ash_pkg::PH_DATA;
            end else begin
               if (rw_r && sel_r != ash_pkg::RI_RESULT && ptr_r != 2'h3) begin
                  regs_nxt[sel_r][{ptr_r, 3'h0} +: 8] = done_byte;
               end
               if (!rw_r && sel_r == ash_pkg::RI_RESULT && ptr_r != 2'h3) begin
                  rmask_nxt[ptr_r] = 1'b1;
               end
               if (regs_r[ash_pkg::RI_CTRL][ash_pkg::CTRL_ASC_BIT]) begin
                  ptr_nxt = ptr_r + 2'h1;
               end else begin
                  ptr_nxt = ptr_r - 2'h1;
               end
               // remaining bytes survive a suspend and run before a new instruction
               if (left_r == 2'h0) begin
                  phase_nxt = ash_pkg::PH_INSTR;
               end else begin
                  left_nxt = left_r - 2'h1;
               end
            end
         end
      end
      // a new result wins over a read finishing in the same cycle
      if (conv_load) begin
         regs_nxt[ash_pkg::RI_RESULT] = conv_result;
         rmask_nxt = 3'h0;
         pend_n_nxt = 1'b0;
      end else if (&rmask_nxt) begin
         rmask_nxt = 3'h0;
         pend_n_nxt = 1'b1;
      end
      sdio_oe_nxt = reading && drive_en && bidir;
      sol_oe_nxt = reading && drive_en && !bidir;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_r <= ash_pkg::PH_INSTR;
         for (int i = 0; i < ash_pkg::NUM_REGS; i++) begin
            regs_r[i] <= ash_pkg::REG_RST;
         end
         rw_r <= 1'b0;
         left_r <= 2'h0;
         sel_r <= ash_pkg::RI_RESULT;
         ptr_r <= 2'h0;
         bit_r <= 3'h0;
         sh_r <= 8'h00;
         rmask_r <= 3'h0;
         pend_n_r <= 1'b1;
         dout_r <= 1'b0;
         sdio_oe_r <= 1'b0;
         sol_oe_r <= 1'b0;
         sclk_prev_r <= 1'b1;
      end else begin
         phase_r <= phase_nxt;
         regs_r <= regs_nxt;
         rw_r <= rw_nxt;
         left_r <= left_nxt;
         sel_r <= sel_nxt;
         ptr_r <= ptr_nxt;
         bit_r <= bit_nxt;
         sh_r <= sh_nxt;
         rmask_r <= rmask_nxt;
         pend_n_r <= pend_n_nxt;
         dout_r <= dout_nxt;
         sdio_oe_r <= sdio_oe_nxt;
         sol_oe_r <= sol_oe_nxt;
         // tracked even while deselected so a restored level gives no edge
         sclk_prev_r <= link.sclk;
      end
   end

   // =====================================================================
   // outputs
   assign link.sclk_dev_o = sclk_r;
   assign link.sclk_dev_oe = sclk_oe_r;
   assign link.sdio_dev_o = dout_r;
   assign link.sdio_dev_oe = sdio_oe_r;
   assign link.serial_out_line_o = dout_r;
   assign link.serial_out_line_oe = sol_oe_r;
   assign link.result_pending_n = pend_n_r;
   assign setup_control = regs_r[ash_pkg::RI_CTRL];
   assign zero_point_cal = regs_r[ash_pkg::RI_ZERO];
   assign positive_span_cal = regs_r[ash_pkg::RI_PSPAN];
   assign negative_span_cal = regs_r[ash_pkg::RI_NSPAN];

endmodule : ash_dev_port

// File: src/ash_pkg.sv
// constants, types and field layout shared by both ends of the serial port
// Notes on behaviour
// - mode low: serial clock is host-driven input
// - mode high: device drives clock at osc/8
// - chip select sampled; first edge after 29 cycles
// - eight clock cycles per byte, 28-cycle high stall
// - external clock: chip select high freezes engine
// - host keeps clock level across a suspend
// - external clock: read outputs released on deselect
// - self clock: started byte always completes
// - self clock: deselected stays stalled high forever
// - interrupted transfer resumes before next instruction
// - self clock: outputs drop one cycle after stall
// - bidirectional mode: dedicated output never driven
// - writes on data line; reads there if bidir
// - external clock, deselected: both data lines released, cycle suspended
// - host clock no faster than 5 MHz
// - ready flag low on new result, high after read
// - byte addressing, bit and byte order selectable
// - result read-only, four 24-bit read/write registers
// - host may tie chip select low
// - instruction byte first, then its data bytes
// - write data captured on rising serial clock
package ash_pkg;
   // =====================================================================
   // timing
   localparam int PCLK_NS = 100;
   localparam int OSC_DIV = 8;
   localparam int BYTE_TICKS = 8 * OSC_DIV;
   localparam int LEAD_CYC = 29;
   localparam int STALL_CYC = 28;
   localparam int SCLK_MAX_KHZ = 5000;
   localparam int SCLK_MIN_HALF_NS = 1000000 / (2 * SCLK_MAX_KHZ);
   localparam int HALF_MIN_CYC = (SCLK_MIN_HALF_NS + PCLK_NS - 1) / PCLK_NS;
   // device samples the clock pin and answers one cycle later, so reads need slack
   localparam int HOST_HALF_CYC = HALF_MIN_CYC + 3;
   // =====================================================================
   // device registers
   localparam int NUM_REGS = 5;
   localparam logic [2:0] RI_RESULT = 3'h0;
   localparam logic [2:0] RI_CTRL = 3'h1;
   localparam logic [2:0] RI_ZERO = 3'h2;
   localparam logic [2:0] RI_PSPAN = 3'h3;
   localparam logic [2:0] RI_NSPAN = 3'h4;
   localparam logic [23:0] REG_RST = 24'h000000;
   localparam int CTRL_BIDIR_BIT = 0;
   localparam int CTRL_LSBF_BIT = 1;
   localparam int CTRL_ASC_BIT = 2;
   // instruction byte
   localparam int INS_RW_BIT = 7;
   localparam int INS_MB_LSB = 5;
   localparam int INS_FSC_BIT = 4;
   localparam int INS_REG_LSB = 2;
   localparam int INS_BYTE_LSB = 0;
   // =====================================================================
   // host command registers
   localparam logic [7:0] HR_CTRL = 8'h00;
   localparam logic [7:0] HR_CMD = 8'h04;
   localparam logic [7:0] HR_TX = 8'h08;
   localparam logic [7:0] HR_RX = 8'h0C;
   localparam logic [7:0] HR_STAT = 8'h10;
   localparam int HCTRL_SELF_BIT = 0;
   localparam int HCTRL_BIDIR_BIT = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_PEND_N_BIT = 1;
   // =====================================================================
   // types
   typedef enum logic {PH_INSTR, PH_DATA} ash_phase_t;
   typedef enum logic [1:0] {SC_IDLE, SC_LEAD, SC_SHIFT, SC_STALL} ash_sc_t;
   typedef enum logic [1:0] {HS_IDLE, HS_RUN, HS_END} ash_hst_t;
endpackage : ash_pkg

// File: src/ash_link_if.sv
// serial link between the converter port and its host, with pin resolution
`timescale 1ns/1ns
interface ash_link_if;
   logic clock_mode;
   logic cs_n;
   logic result_pending_n;
   logic sclk_dev_o;
   logic sclk_dev_oe;
   logic sclk_host_o;
   logic sclk_host_oe;
   logic sclk;
   logic sdio_dev_o;
   logic sdio_dev_oe;
   logic sdio_host_o;
   logic sdio_host_oe;
   logic sdio;
   logic serial_out_line_o;
   logic serial_out_line_oe;
   logic serial_out_line;
   // undriven lines float to the pull-up level
   assign sclk = sclk_dev_oe ? sclk_dev_o : (sclk_host_oe ? sclk_host_o : 1'b1);
   assign sdio = sdio_dev_oe ? sdio_dev_o : (sdio_host_oe ? sdio_host_o : 1'b1);
   assign serial_out_line = serial_out_line_oe ? serial_out_line_o : 1'b1;
   modport dev (
      input clock_mode, cs_n, sclk, sdio,
      output result_pending_n, sclk_dev_o, sclk_dev_oe, sdio_dev_o, sdio_dev_oe,
      output serial_out_line_o, serial_out_line_oe
   );
   modport host (
      input result_pending_n, sclk, sdio, serial_out_line,
      output clock_mode, cs_n, sclk_host_o, sclk_host_oe, sdio_host_o, sdio_host_oe
   );
endinterface : ash_link_if

// File: src/ash_host_port.sv
// host end of the serial port, commanded by software over apb
`timescale 1ns/1ns
module ash_host_port #(
   parameter int HALF_CYC = ash_pkg::HOST_HALF_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial link
   ash_link_if.host link
);
   // =====================================================================
   // apb registers
   logic [1:0] ctrl_r, ctrl_nxt;
   logic [31:0] tx_r, tx_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic err_r, err_nxt;
   logic [31:0] rx_r, rx_nxt;
   ash_pkg::ash_hst_t st_r, st_nxt;
   logic wr, start;

   assign wr = psel && penable && pwrite;
   // a command while busy is dropped
   assign start = wr && paddr == ash_pkg::HR_CMD && st_r == ash_pkg::HS_IDLE;

   always_comb begin
      ctrl_nxt = ctrl_r;
      tx_nxt = tx_r;
      prdata_nxt = prdata_r;
      err_nxt = err_r;
      if (wr && paddr == ash_pkg::HR_CTRL) begin
         ctrl_nxt = pwdata[1:0];
      end
      if (wr && paddr == ash_pkg::HR_TX) begin
         tx_nxt = pwdata;
      end
      // read data and error are prepared in the setup cycle
      if (psel && !penable) begin
         prdata_nxt = 32'h00000000;
         err_nxt = 1'b0;
         unique case (paddr)
            ash_pkg::HR_CTRL: prdata_nxt = {30'h00000000, ctrl_r};
            ash_pkg::HR_CMD: prdata_nxt = 32'h00000000;
            ash_pkg::HR_TX: prdata_nxt = tx_r;
            ash_pkg::HR_RX: prdata_nxt = rx_r;
            ash_pkg::HR_STAT: begin
               prdata_nxt[ash_pkg::STAT_BUSY_BIT] = st_r != ash_pkg::HS_IDLE;
               prdata_nxt[ash_pkg::STAT_PEND_N_BIT] = link.result_pending_n;
            end
            default: err_nxt = 1'b1;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= 2'h0;
         tx_r <= 32'h00000000;
         prdata_r <= 32'h00000000;
         err_r <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         tx_r <= tx_nxt;
         prdata_r <= prdata_nxt;
         err_r <= err_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pslverr = err_r;
   assign pready = 1'b1;

   // =====================================================================
   // link sequencer
   logic [7:0] instr_r, instr_nxt;
   logic [2:0] byte_r, byte_nxt;
   logic [2:0] bit_r, bit_nxt;
   logic [7:0] hcnt_r, hcnt_nxt;
   logic cs_n_r, cs_n_nxt;
   logic sclk_r, sclk_nxt;
   logic sdo_r, sdo_nxt;
   logic sdo_oe_r, sdo_oe_nxt;
   logic sclk_prev_r;
   logic fall, rise, self_mode, last_byte;
   logic [1:0] didx;
   logic [7:0] out_byte;

   assign self_mode = ctrl_r[ash_pkg::HCTRL_SELF_BIT];
   assign didx = 2'(byte_r - 3'h1);
   assign last_byte = byte_r == {1'b0, instr_r[ash_pkg::INS_MB_LSB +: 2]} + 3'h1;
   assign out_byte = (byte_r == 3'h0) ? instr_r : tx_r[{didx, 3'h0} +: 8];

   always_comb begin
      st_nxt = st_r;
      instr_nxt = instr_r;
      byte_nxt = byte_r;
      bit_nxt = bit_r;
      hcnt_nxt = hcnt_r;
      cs_n_nxt = cs_n_r;
      sclk_nxt = sclk_r;
      sdo_nxt = sdo_r;
      rx_nxt = rx_r;
      fall = 1'b0;
      rise = 1'b0;
      if (st_r == ash_pkg::HS_RUN) begin
         if (self_mode) begin
            fall = sclk_prev_r && !link.sclk;
            rise = !sclk_prev_r && link.sclk;
         end else if (hcnt_r == 8'(HALF_CYC - 1)) begin
            // divider keeps the shift clock within the 5 MHz limit
            hcnt_nxt = 8'h00;
            sclk_nxt = !sclk_r;
            fall = sclk_r;
            rise = !sclk_r;
         end else begin
            hcnt_nxt = hcnt_r + 8'h01;
         end
      end
      unique case (st_r)
         ash_pkg::HS_IDLE: begin
            if (start) begin
               instr_nxt = pwdata[7:0];
               byte_nxt = 3'h0;
               bit_nxt = 3'h0;
               hcnt_nxt = 8'h00;
               cs_n_nxt = 1'b0;
               st_nxt = ash_pkg::HS_RUN;
            end
         end
         ash_pkg::HS_RUN: begin
            if (fall) begin
               sdo_nxt = out_byte[3'h7 - bit_r];
            end
            if (rise) begin
               if (byte_r != 3'h0 && !instr_r[ash_pkg::INS_RW_BIT]) begin
                  rx_nxt[{didx, ~bit_r}] = ctrl_r[ash_pkg::HCTRL_BIDIR_BIT] ? link.sdio
                                                                        : link.serial_out_line;
               end
               bit_nxt = bit_r + 3'h1;
               if (bit_r == 3'h7) begin
                  byte_nxt = byte_r + 3'h1;
                  if (last_byte) begin
                     st_nxt = ash_pkg::HS_END;
                  end
               end
            end
         end
         ash_pkg::HS_END: begin
            // hold select one half period past the last rising edge
            hcnt_nxt = hcnt_r + 8'h01;
            if (hcnt_r == 8'(HALF_CYC - 1)) begin
               hcnt_nxt = 8'h00;
               cs_n_nxt = 1'b1;
               st_nxt = ash_pkg::HS_IDLE;
            end
         end
         default: st_nxt = ash_pkg::HS_IDLE;
      endcase
      // the data line is released whenever the device may be reading back on it; with the
      // host clock the device samples the wire one cycle after the rise, so the release
      // after the last instruction bit waits one cycle, or that bit would read as pull-up
      if (self_mode) begin
         sdio_oe_calc(st_nxt, byte_nxt, sdo_oe_nxt);
      end else begin
         sdio_oe_calc(st_r, byte_r, sdo_oe_nxt);
      end
   end

   function automatic void sdio_oe_calc(input ash_pkg::ash_hst_t st, input logic [2:0] bn,
                                        output logic oe);
      oe = st != ash_pkg::HS_IDLE && (bn == 3'h0 || instr_r[ash_pkg::INS_RW_BIT]);
   endfunction : sdio_oe_calc

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= ash_pkg::HS_IDLE;
         instr_r <= 8'h00;
         byte_r <= 3'h0;
         bit_r <= 3'h0;
         hcnt_r <= 8'h00;
         cs_n_r <= 1'b1;
         sclk_r <= 1'b1;
         sdo_r <= 1'b1;
         sdo_oe_r <= 1'b0;
         rx_r <= 32'h00000000;
         sclk_prev_r <= 1'b1;
      end else begin
         st_r <= st_nxt;
         instr_r <= instr_nxt;
         byte_r <= byte_nxt;
         bit_r <= bit_nxt;
         hcnt_r <= hcnt_nxt;
         cs_n_r <= cs_n_nxt;
         sclk_r <= sclk_nxt;
         sdo_r <= sdo_nxt;
         sdo_oe_r <= sdo_oe_nxt;
         rx_r <= rx_nxt;
         sclk_prev_r <= link.sclk;
      end
   end

   // select stays low over the whole cycle; tying it low is left to the system
   assign link.cs_n = cs_n_r;
   assign link.clock_mode = ctrl_r[ash_pkg::HCTRL_SELF_BIT];
   assign link.sclk_host_o = sclk_r;
   assign link.sclk_host_oe = !ctrl_r[ash_pkg::HCTRL_SELF_BIT];
   assign link.sdio_host_o = sdo_r;
   assign link.sdio_host_oe = sdo_oe_r;

endmodule : ash_host_port

// File: tb/ash_link_asserts.sv
// checker for the serial link between the two port ends
`timescale 1ns/1ns
module ash_link_asserts (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // link pins
   input wire logic clock_mode,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sclk_dev_oe,
   input wire logic sdio_dev_oe,
   input wire logic sdio_host_oe,
   input wire logic serial_out_line_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ==========
   // high-run length of sclk, judged at each fall
   logic [7:0] hi_r;
   logic [7:0] hi_nxt;
   always_comb begin
      hi_nxt = sclk ? ((hi_r == 8'hFF) ? hi_r : hi_r + 8'h01) : 8'h00;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) hi_r <= 8'h00;
      else hi_r <= hi_nxt;
   end
   // ==========
   // assertions
   a_ext_no_drive: assert property (!clock_mode && !$past(clock_mode) |-> !sclk_dev_oe)
      else $error("device drives sclk in external mode");
   a_self_low_dev: assert property (clock_mode && !sclk |-> sclk_dev_oe)
      else $error("sclk low without device drive");
   a_self_lead: assert property ($fell(cs_n) && clock_mode && sclk |-> ##29 sclk ##1 !sclk)
      else $error("self clock lead wrong");
   a_self_byte: assert property ($fell(sclk) && clock_mode |-> !sclk[*4] ##1 sclk[*4])
      else $error("self clock half period wrong");
   a_self_stall: assert property ($fell(sclk) && clock_mode |->
      hi_r == 8'h04 || hi_r == 8'h20 || hi_r > 8'h28)
      else $error("self clock stall wrong");
   a_idle_high: assert property (clock_mode && cs_n && hi_r > 8'h28 |=> sclk)
      else $error("sclk left stall while deselected");
   a_deselect_off: assert property (!clock_mode && cs_n && $past(cs_n) |->
      !sdio_dev_oe && !serial_out_line_oe)
      else $error("data line driven while deselected");
   a_sdo_exclusive: assert property (sdio_dev_oe |-> !serial_out_line_oe)
      else $error("both read lines driven");
   a_sdio_one_drv: assert property (sdio_dev_oe |-> !sdio_host_oe)
      else $error("data line driven from both ends");
   a_ext_rate: assert property (!clock_mode && $changed(sclk) |=> $stable(sclk))
      else $error("external sclk too fast");
   c_self_start: cover property ($fell(cs_n) && clock_mode);
   c_bidir_read: cover property (sdio_dev_oe);
   c_sdo_read: cover property (serial_out_line_oe);
endmodule : ash_link_asserts

// File: tb/adc_serial_host_port_tb_top.sv
// bench: host and device ends joined through the link interface
`timescale 1ns/1ns
module adc_serial_host_port_tb_top;
   // ==========
   // stimulus and observed signals
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic conv_load = 1'b0;
   logic [23:0] conv_result = 24'h0;
   logic [23:0] ctl;
   logic [23:0] zcal;
   logic [23:0] pcal;
   logic [23:0] ncal;
   logic sdo_seen = 1'b0;
   logic [31:0] q;
   logic e;
   int mismatches = 0;
   int checks = 0;
   int cyc = 0;
   ash_link_if ash_link_if_i ();
   ash_dev_port ash_dev_port_i (.pclk(pclk), .presetn(presetn), .link(ash_link_if_i.dev),
      .conv_load(conv_load), .conv_result(conv_result), .setup_control(ctl),
      .zero_point_cal(zcal), .positive_span_cal(pcal), .negative_span_cal(ncal));
   ash_host_port ash_host_port_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(ash_link_if_i.host));
   ash_link_asserts ash_link_asserts_i (.pclk(pclk), .presetn(presetn),
      .clock_mode(ash_link_if_i.clock_mode), .cs_n(ash_link_if_i.cs_n),
      .sclk(ash_link_if_i.sclk), .sclk_dev_oe(ash_link_if_i.sclk_dev_oe),
      .sdio_dev_oe(ash_link_if_i.sdio_dev_oe), .sdio_host_oe(ash_link_if_i.sdio_host_oe),
      .serial_out_line_oe(ash_link_if_i.serial_out_line_oe));
   initial forever #50 pclk = ~pclk;
   // a hang is cut short well above the longest expected run
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         mismatches++;
         close_out();
      end
   end
   always @(posedge pclk) if (ash_link_if_i.serial_out_line_oe === 1'b1) sdo_seen <= 1'b1;
   // ==========
   // shared tasks
   task automatic close_out();
      $display("mismatches=%0d checks=%0d", mismatches, checks);
      if (mismatches == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // spacing after each cycle lets the self-clocked engine settle back to idle
   task automatic cmd(input logic [7:0] ins, input logic [31:0] tx);
      apb(1'b1, ash_pkg::HR_TX, tx);
      apb(1'b1, ash_pkg::HR_CMD, {24'h0, ins});
      q = 32'h1;
      while (q[ash_pkg::STAT_BUSY_BIT] !== 1'b0) apb(1'b0, ash_pkg::HR_STAT, 32'h0);
      repeat (40) @(posedge pclk);
   endtask : cmd
   task automatic rd(input logic [7:0] ins, input logic [31:0] exp);
      cmd(ins, 32'h0);
      apb(1'b0, ash_pkg::HR_RX, 32'h0);
      chk(q & 32'h00FFFFFF, exp);
   endtask : rd
   // ==========
   // scenarios
   task automatic t_reset();
      apb(1'b0, ash_pkg::HR_STAT, 32'h0);
      chk(q, 32'h2);
      apb(1'b0, 8'h14, 32'h0);
      chk({q[30:0], e}, 32'h1);
      chk({8'h0, ctl}, 32'h0);
   endtask : t_reset
   task automatic t_write();
      cmd(8'hCA, 32'h00332211);
      cmd(8'hCE, 32'h00665544);
      cmd(8'hDE, 32'h00998877);
      chk({8'h0, zcal}, 32'h112233);
      chk({8'h0, pcal}, 32'h445566);
      chk({8'h0, ncal}, 32'h778899);
   endtask : t_write
   task automatic t_result();
      @(posedge pclk);
      conv_result <= 24'hA5C3E1;
      conv_load <= 1'b1;
      @(posedge pclk);
      conv_load <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({31'h0, ash_link_if_i.result_pending_n}, 32'h0);
      cmd(8'hC2, 32'h00FFFFFF);
      cmd(8'h02, 32'h0);
      chk({31'h0, ash_link_if_i.result_pending_n}, 32'h0);
      rd(8'h42, 32'h00E1C3A5);
      chk({31'h0, ash_link_if_i.result_pending_n}, 32'h1);
   endtask : t_result
   task automatic t_order();
      cmd(8'h84, 32'h6);
      chk({8'h0, ctl}, 32'h6);
      rd(8'h48, 32'h008844CC);
      cmd(8'h84, 32'h0);
   endtask : t_order
   task automatic t_self();
      apb(1'b1, ash_pkg::HR_CTRL, 32'h1);
      rd(8'h4E, 32'h00665544);
      cmd(8'hDE, 32'h00123456);
      chk({8'h0, ncal}, 32'h563412);
      apb(1'b1, ash_pkg::HR_CTRL, 32'h0);
   endtask : t_self
   task automatic t_bidir();
      cmd(8'h84, 32'h1);
      apb(1'b1, ash_pkg::HR_CTRL, 32'h2);
      sdo_seen = 1'b0;
      rd(8'h4E, 32'h00665544);
      chk({31'h0, sdo_seen}, 32'h0);
      apb(1'b1, ash_pkg::HR_CTRL, 32'h0);
      cmd(8'h84, 32'h0);
   endtask : t_bidir
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_write();
      t_result();
      t_order();
      t_self();
      t_bidir();
      close_out();
   end
endmodule : adc_serial_host_port_tb_top
